// ### hdl/pfm_pkg.sv
// Package: constants, types and helpers for the pad function mux
package pfm_pkg;

  localparam int PFM_NPADS = 5;
  localparam int PFM_NMODES = 16;
  localparam int PFM_NSYNC = 8;

  // Register byte addresses
  localparam logic [31:0] PFM_ADDR_TEN = 32'h4402_E0C8;
  localparam logic [31:0] PFM_ADDR_ELEVEN = 32'h4402_E0CC;
  localparam logic [31:0] PFM_ADDR_FOURTEEN = 32'h4402_E0D8;
  localparam logic [31:0] PFM_ADDR_FIFTEEN = 32'h4402_E0DC;
  localparam logic [31:0] PFM_ADDR_SIXTEEN = 32'h4402_E0E0;
  localparam logic [31:0] PFM_ADDR_CTRL = 32'h4402_E200;

  // Decoded register index; pads take 0 to 4
  localparam logic [2:0] PFM_IDX_CTRL = 3'h5;
  localparam logic [2:0] PFM_IDX_NONE = 3'h7;
  localparam logic [2:0] PFM_IDX_PADS = 3'h5;

  // Pad config word layout
  localparam int PFM_F_MODE_LSB = 0;
  localparam int PFM_F_DRIVE_LSB = 5;
  localparam int PFM_F_PULL_UP = 8;
  localparam int PFM_F_PULL_DN = 9;
  localparam int PFM_F_HIB_DRIVE = 10;
  localparam int PFM_F_HIB_LEVEL = 11;

  // Control word layout
  localparam int PFM_C_BOOT = 0;
  localparam int PFM_C_STRAP = 1;
  localparam int PFM_C_SLEEP = 2;
  localparam int PFM_C_HIB = 3;

  // Synchroniser lanes: pads 0 to 4, then power states and strap
  localparam int PFM_S_SLEEP = 5;
  localparam int PFM_S_HIB = 6;
  localparam int PFM_S_STRAP = 7;

  localparam logic [3:0] PFM_MODE_GPIO = 4'h0;
  localparam logic [3:0] PFM_MODE_BOOT = 4'h1;
  localparam logic [1:0] PFM_DRV_6MA = 2'h2;
  localparam logic [1:0] PFM_DRV_RSV = 2'h3;
  localparam logic [2:0] PFM_HSIZE_WORD = 3'h2;
  localparam logic [1:0] PFM_STRAP_WAIT = 2'h2;

  // Per-pad mode masks, pad 0 in the low word
  localparam logic [PFM_NPADS-1:0][15:0] PFM_VALID =
    {16'h21B1, 16'h21B1, 16'h10B1, 16'h30DB, 16'h10CB};
  localparam logic [PFM_NPADS-1:0][15:0] PFM_OUT =
    {16'h01A1, 16'h01A1, 16'h00A1, 16'h205B, 16'h00CB};
  localparam logic [PFM_NPADS-1:0][15:0] PFM_OD =
    {16'h0000, 16'h0020, 16'h0020, 16'h0042, 16'h0002};
  localparam logic [PFM_NPADS-1:0][15:0] PFM_HOLD_HI =
    {16'h0020, 16'h0000, 16'h0000, 16'h0000, 16'h0080};
  localparam logic [PFM_NPADS-1:0][15:0] PFM_HOLD_LO =
    {16'h0100, 16'h0000, 16'h0000, 16'h0010, 16'h0040};

  typedef struct packed {
    logic hib_level;
    logic hib_drive;
    logic pull_dn;
    logic pull_up;
    logic [1:0] drive;
    logic [3:0] mode;
  } pfm_cfg_type;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pfm_src_type;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_dn;
    logic [1:0] drive;
  } pfm_pad_type;

  typedef enum logic [2:0] {
    PFM_ST_RESET = 3'b001,
    PFM_ST_SENSE = 3'b010,
    PFM_ST_RUN = 3'b100
  } pfm_state_type;

  localparam pfm_cfg_type PFM_CFG_RESET = 10'h000;
  localparam pfm_pad_type PFM_PAD_RESET = 6'h10;

  function automatic pfm_cfg_type pfm_cfg_from_word(input logic [31:0] w);
    pfm_cfg_type c;
    c.mode = w[PFM_F_MODE_LSB +: 4];
    c.drive = w[PFM_F_DRIVE_LSB +: 2];
    c.pull_up = w[PFM_F_PULL_UP];
    c.pull_dn = w[PFM_F_PULL_DN];
    c.hib_drive = w[PFM_F_HIB_DRIVE];
    c.hib_level = w[PFM_F_HIB_LEVEL];
    return c;
  endfunction

  function automatic logic [31:0] pfm_cfg_to_word(input pfm_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PFM_F_MODE_LSB +: 4] = c.mode;
    w[PFM_F_DRIVE_LSB +: 2] = c.drive;
    w[PFM_F_PULL_UP] = c.pull_up;
    w[PFM_F_PULL_DN] = c.pull_dn;
    w[PFM_F_HIB_DRIVE] = c.hib_drive;
    w[PFM_F_HIB_LEVEL] = c.hib_level;
    return w;
  endfunction

  // Reserved drive code maps to the strongest level
  function automatic logic [1:0] pfm_drive_code(input logic [1:0] d);
    return (d == PFM_DRV_RSV) ? PFM_DRV_6MA : d;
  endfunction

endpackage

// ### hdl/pfm_pad_slot.sv
// Pad slot: one pad's function select and state override
`timescale 1ns/1ns
`default_nettype none

module pfm_pad_slot (
  input wire pfm_pkg::pfm_cfg_type cfg,
  input wire logic [15:0] valid_mask,
  input wire logic [15:0] out_mask,
  input wire logic [15:0] od_mask,
  input wire logic [15:0] hi_mask,
  input wire logic [15:0] lo_mask,
  input wire pfm_pkg::pfm_src_type src,
  input wire logic sleep,
  input wire logic hib,
  output var pfm_pkg::pfm_pad_type pad_next
);

  logic [3:0] mode_sel;
  logic is_valid;
  logic can_out;
  logic is_od;
  logic sel_out;
  logic sel_oe;
  logic fn_oe_n;
  logic fn_out;
  logic hold_hi;
  logic hold_lo;

  assign mode_sel = cfg.mode;
  assign is_valid = valid_mask[mode_sel];
  assign can_out = is_valid & out_mask[mode_sel];
  assign is_od = od_mask[mode_sel];
  assign sel_out = src.out[mode_sel];
  assign sel_oe = src.oe[mode_sel];
  // Open drain only pulls low; a high releases the pad
  assign fn_oe_n = !(can_out & sel_oe & (!is_od | !sel_out));
  assign fn_out = is_od ? 1'b0 : sel_out;
  assign hold_hi = sleep & is_valid & hi_mask[mode_sel];
  assign hold_lo = sleep & is_valid & lo_mask[mode_sel];

  always_comb begin
    pad_next.drive = pfm_pkg::pfm_drive_code(cfg.drive);
    pad_next.pull_up = cfg.pull_up;
    pad_next.pull_dn = cfg.pull_dn;
    if (hib) begin
      pad_next.oe_n = !cfg.hib_drive;
      pad_next.out = cfg.hib_level;
    end else if (hold_hi) begin
      pad_next.oe_n = 1'b0;
      pad_next.out = 1'b1;
    end else if (hold_lo) begin
      pad_next.oe_n = 1'b0;
      pad_next.out = 1'b0;
    end else begin
      pad_next.oe_n = fn_oe_n;
      pad_next.out = fn_out;
    end
  end

endmodule

`default_nettype wire

// ### hdl/pfm_top.sv
// Top: AHB-Lite register file and pad function mux
`timescale 1ns/1ns
`default_nettype none

module pfm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pfm_pkg::pfm_src_type [pfm_pkg::PFM_NPADS-1:0] pad_src,
  input wire logic [pfm_pkg::PFM_NPADS-1:0] pad_in,
  input wire logic sleep_in,
  input wire logic hib_in,
  input wire logic strap_in,
  output var pfm_pkg::pfm_pad_type [pfm_pkg::PFM_NPADS-1:0] pad_ctl,
  output logic [pfm_pkg::PFM_NPADS-1:0] pad_rx,
  output logic [3:0] boot_pad_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [2:0] pfm_decode(input logic [31:0] a);
    logic [2:0] idx;
    if (a == pfm_pkg::PFM_ADDR_TEN) begin
      idx = 3'h0;
    end else if (a == pfm_pkg::PFM_ADDR_ELEVEN) begin
      idx = 3'h1;
    end else if (a == pfm_pkg::PFM_ADDR_FOURTEEN) begin
      idx = 3'h2;
    end else if (a == pfm_pkg::PFM_ADDR_FIFTEEN) begin
      idx = 3'h3;
    end else if (a == pfm_pkg::PFM_ADDR_SIXTEEN) begin
      idx = 3'h4;
    end else if (a == pfm_pkg::PFM_ADDR_CTRL) begin
      idx = pfm_pkg::PFM_IDX_CTRL;
    end else begin
      idx = pfm_pkg::PFM_IDX_NONE;
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [pfm_pkg::PFM_NSYNC-1:0] sync1_reg;
  logic [pfm_pkg::PFM_NSYNC-1:0] sync2_reg;
  logic sleep_s;
  logic hib_s;
  logic strap_s;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {strap_in, hib_in, sleep_in, pad_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign sleep_s = sync2_reg[pfm_pkg::PFM_S_SLEEP];
  assign hib_s = sync2_reg[pfm_pkg::PFM_S_HIB];
  assign strap_s = sync2_reg[pfm_pkg::PFM_S_STRAP];
  assign pad_rx = sync2_reg[pfm_pkg::PFM_NPADS-1:0];

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  logic addr_ok;
  logic wr_pend_next;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic wr_pad;
  logic wr_ctrl;

  assign addr_ok = hsel & hready & htrans[1];
  // Sub-word writes are dropped; only whole-word writes are mapped
  assign wr_pend_next = addr_ok & hwrite & (hsize == pfm_pkg::PFM_HSIZE_WORD);
  assign wr_idx = pfm_decode(wr_addr_reg);
  assign rd_idx = pfm_decode(haddr);
  assign wr_pad = wr_pend_reg & (wr_idx < pfm_pkg::PFM_IDX_PADS);
  assign wr_ctrl = wr_pend_reg & (wr_idx == pfm_pkg::PFM_IDX_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= haddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad config registers and boot state

  pfm_pkg::pfm_cfg_type [pfm_pkg::PFM_NPADS-1:0] cfg_reg;
  pfm_pkg::pfm_cfg_type [pfm_pkg::PFM_NPADS-1:0] cfg_next;
  logic boot_reg;
  logic boot_next;
  logic strap_reg;
  logic strap_next;
  logic [1:0] sense_cnt_reg;
  logic [1:0] sense_cnt_next;
  pfm_pkg::pfm_state_type state_reg;
  pfm_pkg::pfm_state_type state_next;
  logic [31:0] rd_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_pad) begin
      cfg_next[wr_idx] = pfm_pkg::pfm_cfg_from_word(hwdata);
    end
  end

  // Boot flag is sticky until reset
  assign boot_next = boot_reg | (wr_ctrl & hwdata[pfm_pkg::PFM_C_BOOT]);

  // Strap is sampled once the synchroniser has settled after release
  always_comb begin
    state_next = state_reg;
    sense_cnt_next = sense_cnt_reg;
    strap_next = strap_reg;
    case (state_reg)
      pfm_pkg::PFM_ST_RESET: begin
        state_next = pfm_pkg::PFM_ST_SENSE;
      end
      pfm_pkg::PFM_ST_SENSE: begin
        sense_cnt_next = sense_cnt_reg + 2'h1;
        if (sense_cnt_reg == pfm_pkg::PFM_STRAP_WAIT) begin
          strap_next = strap_s;
          state_next = pfm_pkg::PFM_ST_RUN;
        end
      end
      pfm_pkg::PFM_ST_RUN: begin
        state_next = pfm_pkg::PFM_ST_RUN;
      end
      default: begin
        state_next = pfm_pkg::PFM_ST_RESET;
      end
    endcase
  end

  // Reads see this cycle's write, so back-to-back write then read is exact
  always_comb begin
    rd_next = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      if (rd_idx < pfm_pkg::PFM_IDX_PADS) begin
        rd_next = pfm_pkg::pfm_cfg_to_word(cfg_next[rd_idx]);
      end else if (rd_idx == pfm_pkg::PFM_IDX_CTRL) begin
        rd_next[pfm_pkg::PFM_C_BOOT] = boot_next;
        rd_next[pfm_pkg::PFM_C_STRAP] = strap_reg;
        rd_next[pfm_pkg::PFM_C_SLEEP] = sleep_s;
        rd_next[pfm_pkg::PFM_C_HIB] = hib_s;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= {pfm_pkg::PFM_NPADS{pfm_pkg::PFM_CFG_RESET}};
      boot_reg <= 1'b0;
      strap_reg <= 1'b0;
      sense_cnt_reg <= 2'h0;
      state_reg <= pfm_pkg::PFM_ST_RESET;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      boot_reg <= boot_next;
      strap_reg <= strap_next;
      sense_cnt_reg <= sense_cnt_next;
      state_reg <= state_next;
      hrdata <= rd_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad drivers

  pfm_pkg::pfm_pad_type [pfm_pkg::PFM_NPADS-1:0] pad_next;

  // No cross-pad checks: two pads on one function both drive
  for (genvar i = 0; i < pfm_pkg::PFM_NPADS; i++) begin : g_pad
    pfm_pad_slot u_slot (
      .cfg(cfg_reg[i]),
      .valid_mask(pfm_pkg::PFM_VALID[i]),
      .out_mask(pfm_pkg::PFM_OUT[i]),
      .od_mask(pfm_pkg::PFM_OD[i]),
      .hi_mask(pfm_pkg::PFM_HOLD_HI[i]),
      .lo_mask(pfm_pkg::PFM_HOLD_LO[i]),
      .src(pad_src[i]),
      .sleep(sleep_s),
      .hib(hib_s),
      .pad_next(pad_next[i])
    );
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_ctl <= {pfm_pkg::PFM_NPADS{pfm_pkg::PFM_PAD_RESET}};
      boot_pad_mode <= pfm_pkg::PFM_MODE_GPIO;
    end else begin
      pad_ctl <= pad_next;
      boot_pad_mode <= (boot_next | strap_next) ? pfm_pkg::PFM_MODE_BOOT
                                                 : pfm_pkg::PFM_MODE_GPIO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_strap_boot: assert property (
    state_reg == pfm_pkg::PFM_ST_SENSE && sense_cnt_reg == pfm_pkg::PFM_STRAP_WAIT
    && strap_s |=> ##1 boot_pad_mode == pfm_pkg::PFM_MODE_BOOT
  ) else $error("strap did not select boot mode");

  a_mode_store: assert property (
    wr_pad && wr_idx == 3'h0 |=>
    cfg_reg[0].mode == $past(hwdata[pfm_pkg::PFM_F_MODE_LSB +: 4])
  ) else $error("pad ten mode not stored");

  a_drive_level: assert property (
    ##1 pad_ctl[1].drive == pfm_pkg::pfm_drive_code($past(cfg_reg[1].drive))
  ) else $error("drive strength mismatch");

  a_pull_follow: assert property (
    ##1 pad_ctl[2].pull_up == $past(cfg_reg[2].pull_up)
    && pad_ctl[2].pull_dn == $past(cfg_reg[2].pull_dn)
  ) else $error("pull setting mismatch");

  a_hib_float: assert property (
    hib_s && !cfg_reg[3].hib_drive |=> pad_ctl[3].oe_n
  ) else $error("pad driven in hibernate");

  a_gpio_float: assert property (
    !hib_s && !sleep_s && cfg_reg[4].mode == pfm_pkg::PFM_MODE_GPIO
    && !pad_src[4].oe[0] |=> pad_ctl[4].oe_n
  ) else $error("idle gpio pad driven");

  a_boot_mode: assert property (
    wr_ctrl && hwdata[pfm_pkg::PFM_C_BOOT] |=>
    (boot_pad_mode == pfm_pkg::PFM_MODE_BOOT) [*2]
  ) else $error("boot pads not in mode 1");

  a_sleep_tx_high: assert property (
    sleep_s && !hib_s && cfg_reg[0].mode == 4'h7 |=> pad_ctl[0].out && !pad_ctl[0].oe_n
  ) else $error("uart transmit not held high");

  a_sleep_clk_low: assert property (
    sleep_s && !hib_s && cfg_reg[1].mode == 4'h4 |=> !pad_ctl[1].out && !pad_ctl[1].oe_n
  ) else $error("camera clock not held low");

  a_gen_serial_clock_pass: assert property (
    !sleep_s && !hib_s && cfg_reg[2].mode == 4'h7 && pad_src[2].oe[7]
    |=> pad_ctl[2].out == $past(pad_src[2].out[7]) && !pad_ctl[2].oe_n
  ) else $error("serial clock not routed");

  a_od_release: assert property (
    !hib_s && cfg_reg[3].mode == 4'h5 && pad_src[3].out[5] |=> pad_ctl[3].oe_n
  ) else $error("open drain drove high");

  a_bad_mode: assert property (
    !hib_s && cfg_reg[4].mode == 4'h2 |=> pad_ctl[4].oe_n
  ) else $error("unmapped mode drove pad");

  c_pad_write: cover property (wr_pad ##1 addr_ok && !hwrite);
  c_boot: cover property ($rose(boot_pad_mode[0]));
  c_sleep_hold: cover property (sleep_s && !hib_s && cfg_reg[0].mode == 4'h7);
  c_hib_drive: cover property (hib_s && cfg_reg[0].hib_drive);

endmodule

`default_nettype wire

// ### tb/tb.sv
// Testbench for the pad function mux: register bus, mode decode, power states, boot
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  pfm_pkg::pfm_src_type [pfm_pkg::PFM_NPADS-1:0] pad_src;
  logic [4:0] pad_in;
  logic sleep_in;
  logic hib_in;
  logic strap_in;
  pfm_pkg::pfm_pad_type [pfm_pkg::PFM_NPADS-1:0] pad_ctl;
  logic [4:0] pad_rx;
  logic [3:0] boot_pad_mode;
  int bad_count;
  int checks;
  logic [31:0] rd;
  logic exp_drv;
  logic [31:0] adr [5];
  // Modes that may drive the pad, and the open-drain subset, per pad
  logic [15:0] drv [5];
  logic [15:0] odm [5];
  // Deep sleep holds: pad, mode, held level
  int sp [5];
  logic [3:0] sm [5];
  logic sl [5];

  pfm_top DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .pad_src(pad_src),
    .pad_in(pad_in),
    .sleep_in(sleep_in),
    .hib_in(hib_in),
    .strap_in(strap_in),
    .pad_ctl(pad_ctl),
    .pad_rx(pad_rx),
    .boot_pad_mode(boot_pad_mode)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Level is only meaningful while the pad is driven
  task automatic chk_pad(input int p, input logic oen, input logic out);
    checks++;
    if (pad_ctl[p].oe_n !== oen || (oen === 1'b0 && pad_ctl[p].out !== out)) begin
      bad_count++;
      $display("[ERR] %0t pad %0d oe_n %b out %b", $time, p, pad_ctl[p].oe_n, pad_ctl[p].out);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #10;
  endtask

  // Single transfer; waits on hready rather than assuming zero wait states
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, pfm_pkg::PFM_HSIZE_WORD);
  endtask

  task automatic rdw(input logic [31:0] a);
    xfer(a, 1'b0, 32'h0000_0000, pfm_pkg::PFM_HSIZE_WORD);
  endtask

  task automatic set_src(input logic [15:0] o, input logic [15:0] e);
    @(posedge hclk);
    pad_src <= {5{o, e}};
  endtask

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #10;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 20000);
    bad_count++;
    complete_run();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0000_0000;
    pad_src = '0;
    pad_in = 5'h00;
    sleep_in = 1'b0;
    hib_in = 1'b0;
    strap_in = 1'b0;
    bad_count = 0;
    checks = 0;
    adr = '{pfm_pkg::PFM_ADDR_TEN, pfm_pkg::PFM_ADDR_ELEVEN, pfm_pkg::PFM_ADDR_FOURTEEN,
            pfm_pkg::PFM_ADDR_FIFTEEN, pfm_pkg::PFM_ADDR_SIXTEEN};
    drv = '{16'h00CB, 16'h205B, 16'h00A1, 16'h01A1, 16'h01A1};
    odm = '{16'h0002, 16'h0042, 16'h0020, 16'h0020, 16'h0000};
    sp = '{0, 0, 1, 4, 4};
    sm = '{4'h7, 4'h6, 4'h4, 4'h5, 4'h8};
    sl = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    do_reset();
    chk(32'(hreadyout), 32'h0000_0001, "ready");
    chk(32'(hresp), 32'h0000_0000, "resp");
    for (int p = 0; p < 5; p++) chk_pad(p, 1'b1, 1'b0);
    wt(8);
    chk(32'(boot_pad_mode), 32'h0000_0000, "boot idle");
    // Reset value, field mask, sub-word and unmapped refusal
    for (int p = 0; p < 5; p++) begin
      rdw(adr[p]);
      chk(rd, 32'h0000_0000, "cfg reset");
      wr(adr[p], 32'hFFFF_FFFF);
      xfer(adr[p], 1'b1, 32'h0000_0000, 3'h0);
      rdw(adr[p]);
      chk(rd, 32'h0000_0F6F, "cfg mask");
      wr(adr[p], 32'h0000_0000);
    end
    wr(32'h4402_E0D0, 32'hFFFF_FFFF);
    rdw(32'h4402_E0D0);
    chk(rd, 32'h0000_0000, "unmapped");
    wr(pfm_pkg::PFM_ADDR_CTRL, 32'h0000_0001);
    wt(2);
    chk(32'(boot_pad_mode), 32'h0000_0001, "boot mode");
    // Every mode of every pad: driven, released high, and disabled source
    for (int p = 0; p < 5; p++) begin
      for (int m = 0; m < 16; m++) begin
        wr(adr[p], 32'(m));
        for (int k = 0; k < 3; k++) begin
          set_src((k == 1) ? 16'hFFFF : 16'h0000, (k == 2) ? 16'h0000 : 16'hFFFF);
          wt(2);
          exp_drv = (k == 0) ? drv[p][m] : (k == 1) ? (drv[p][m] & ~odm[p][m]) : 1'b0;
          chk_pad(p, ~exp_drv, k == 1);
        end
      end
      wr(adr[p], 32'h0000_0000);
    end
    // Drive code and pulls on one pad, neighbour untouched
    for (int d = 0; d < 4; d++) begin
      wr(adr[2], 32'((d << 5) | (d << 8)));
      wt(2);
      chk(32'({pad_ctl[2].pull_dn, pad_ctl[2].pull_up, pad_ctl[2].drive}),
          32'(((d >> 1) << 3) | ((d & 1) << 2) | ((d == 3) ? 2 : d)), "drive");
      chk(32'(pad_ctl[3].drive), 32'h0000_0000, "drive other");
    end
    // Hibernate floats by default, then a programmed level
    wr(adr[0], 32'h0000_0003);
    set_src(16'h0000, 16'hFFFF);
    hib_in <= 1'b1;
    wt(5);
    chk_pad(0, 1'b1, 1'b0);
    // Boot bit still set, strap low, only hibernate seen
    rdw(pfm_pkg::PFM_ADDR_CTRL);
    chk(rd & 32'h0000_000F, 32'h0000_0009, "ctrl hib");
    wr(adr[0], 32'h0000_0C03);
    wt(2);
    chk_pad(0, 1'b0, 1'b1);
    @(posedge hclk);
    hib_in <= 1'b0;
    wt(5);
    chk_pad(0, 1'b0, 1'b0);
    // Deep sleep holds against the opposite source level
    for (int i = 0; i < 5; i++) begin
      wr(adr[sp[i]], 32'(sm[i]));
      set_src({16{~sl[i]}}, 16'hFFFF);
      sleep_in <= 1'b1;
      wt(5);
      chk_pad(sp[i], 1'b0, sl[i]);
      rdw(pfm_pkg::PFM_ADDR_CTRL);
      chk(rd & 32'h0000_000F, 32'h0000_0005, "ctrl sleep");
      @(posedge hclk);
      sleep_in <= 1'b0;
      wt(5);
      wr(adr[sp[i]], 32'h0000_0000);
    end
    @(posedge hclk);
    pad_in <= 5'h15;
    wt(4);
    chk(32'(pad_rx), 32'h0000_0015, "pad rx");
    // Strap sensed after a second reset
    @(posedge hclk);
    strap_in <= 1'b1;
    do_reset();
    chk(32'(boot_pad_mode), 32'h0000_0000, "boot in reset");
    for (int i = 0; i < 20 && boot_pad_mode !== 4'h1; i++) wt(1);
    chk(32'(boot_pad_mode), 32'h0000_0001, "strap boot");
    rdw(pfm_pkg::PFM_ADDR_CTRL);
    chk(rd & 32'h0000_0003, 32'h0000_0002, "ctrl");
    complete_run();
  end
endmodule

`default_nettype wire
